// >>> core/dgp_port.v
// Dual general purpose port with change and external edge flags
//
// Notes on behaviour
// - Port A is six bits; direction one tristates, zero drives latch.
// - Data register reads return pin levels; writes update the output latch.
// - Port writes merge sampled pin levels with the addressed bits.
// - A4 feeds the timer clock, drives open drain only, hysteresis input.
// - A5 also feeds the serial port active-low slave select.
// - After reset analog pins have digital buffers off, reading zero.
// - Three-bit config field picks analog or digital; resets to 000.
// - Direction A resets to all six bits set on every reset.
// - Unimplemented register bits read as zero.
// - Port B is eight bits with the same direction encoding.
// - Port B pull-ups on input pins enabled when option bit seven is clear.
// - A pull-up is off for any pin configured as output.
// - Pull-ups are disabled after power-on reset.
// - Input pins B7..B4 compared with value latched at last port B read or write; mismatch sets change flag.
// - Output pins among B7..B4 never take part in the comparison.
// - The change flag can wake the device from sleep.
// - Mismatch keeps setting flag; port B access ends it before clearing.
// - B0 is the external interrupt, edge chosen by option bit six.
// - Direction B and option reset to all ones; latch B resets to zero.
//
// Register access over Avalon-MM was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "dgp_consts.vh"

module dgp_port #(
    parameter [47:0] ANALOG_MAP = `DGP_ANALOG_MAP_DEF
) (
    // Clock and reset
    input  wire                     MCLK_I,
    input  wire                     SYS_RST_I,
    // Avalon-MM slave
    input  wire [`DGP_ADDR_W-1:0]   AVS_ADDRESS_I,
    input  wire                     AVS_READ_I,
    input  wire                     AVS_WRITE_I,
    input  wire [31:0]              AVS_WRITEDATA_I,
    output wire [31:0]              AVS_READDATA_O,
    output wire                     AVS_WAITREQUEST_O,
    // Port A pins
    input  wire [`DGP_PA_W-1:0]     PA_IN_I,
    output wire [`DGP_PA_W-1:0]     PA_OUT_O,
    output wire [`DGP_PA_W-1:0]     PA_OE_O,
    // Port B pins
    input  wire [`DGP_PB_W-1:0]     PB_IN_I,
    output wire [`DGP_PB_W-1:0]     PB_OUT_O,
    output wire [`DGP_PB_W-1:0]     PB_OE_O,
    output wire [`DGP_PB_W-1:0]     PB_PULLUP_O,
    // Peripheral side
    output wire                     TIMER_CLK_O,
    output wire                     SLAVE_SEL_N_O,
    output wire [`DGP_PA_W-1:0]     ANALOG_EN_O,
    output wire                     CHANGE_FLAG_O,
    output wire                     EXT_IRQ_FLAG_O,
    output wire                     WAKE_O
);

    // Register state
    reg  [`DGP_PA_W-1:0] latch_a_ff;
    reg  [`DGP_PB_W-1:0] latch_b_ff;
    reg  [`DGP_PA_W-1:0] dir_a_ff;
    reg  [`DGP_PB_W-1:0] dir_b_ff;
    reg  [7:0]           option_ff;
    reg  [2:0]           analog_cfg_ff;
    reg                  change_flag_ff;
    reg                  ext_flag_ff;
    reg  [3:0]           last_read_ff;
    reg                  ext_pin_ff;
    reg                  ack_ff;
    reg  [31:0]          rdata_ff;

    // Next values
    reg  [`DGP_PA_W-1:0] nxt_latch_a;
    reg  [`DGP_PB_W-1:0] nxt_latch_b;
    reg  [`DGP_PA_W-1:0] nxt_dir_a;
    reg  [`DGP_PB_W-1:0] nxt_dir_b;
    reg  [7:0]           nxt_option;
    reg  [2:0]           nxt_analog_cfg;
    reg                  nxt_change_flag;
    reg                  nxt_ext_flag;
    reg  [3:0]           nxt_last_read;
    reg  [31:0]          nxt_rdata;

    // Decode
    wire [7:0]           reg_idx;
    wire                 req;
    wire                 done;
    wire                 wr_done;
    wire                 rd_done;
    wire [7:0]           wr_mask;
    wire [`DGP_PA_W-1:0] analog_en;
    wire [`DGP_PA_W-1:0] pin_a_rd;
    wire [3:0]           mismatch_bits;
    wire                 mismatch;
    wire                 ext_edge;
    wire                 b_access;

    // Helpers
    wire                 ext_pin_now;
    wire                 ext_rise;
    wire                 ext_fall;
    wire                 rd_capture;
    wire                 sel_port_b;
    wire                 sel_int_ctrl;
    wire                 int_wr;
    wire                 pullup_on;
    wire [3:0]           watch_in;
    wire [3:0]           watch_en;
    wire [5:0]           analog_base;
    wire [`DGP_PA_W-1:0] merge_a;
    wire [`DGP_PB_W-1:0] merge_b;

    assign reg_idx  = AVS_ADDRESS_I[`DGP_ADDR_W-1:2];
    assign req      = AVS_READ_I | AVS_WRITE_I;
    assign done     = req & ack_ff;
    assign wr_done  = AVS_WRITE_I & ack_ff;
    assign rd_done  = AVS_READ_I & ack_ff;
    assign rd_capture   = AVS_READ_I & ~ack_ff;
    assign sel_port_b   = (reg_idx == `DGP_IDX_PORT_B);
    assign sel_int_ctrl = (reg_idx == `DGP_IDX_INT_CTRL);
    assign int_wr       = wr_done & sel_int_ctrl;

    // One wait cycle per access
    assign AVS_WAITREQUEST_O = req & ~ack_ff;
    assign AVS_READDATA_O    = rdata_ff;

    // Bits being altered by a write; all bits unless a mask is given
    assign wr_mask = AVS_WRITEDATA_I[`DGP_WR_MASK_EN] ?
                     AVS_WRITEDATA_I[`DGP_WR_MASK_LSB+7:`DGP_WR_MASK_LSB] : 8'hFF;

    // Table lookup of analog pins
    assign analog_base = {3'h0, analog_cfg_ff} * 6'h06;
    assign analog_en   = ANALOG_MAP[analog_base +: 6];

    // Digital input buffers off on analog pins
    assign pin_a_rd = PA_IN_I & ~analog_en;

    // Read-modify-write: unmasked bits take the present pin level
    assign merge_a = (pin_a_rd & ~wr_mask[5:0]) |
                     (AVS_WRITEDATA_I[5:0] & wr_mask[5:0]);
    assign merge_b = (PB_IN_I & ~wr_mask) |
                     (AVS_WRITEDATA_I[7:0] & wr_mask);

    // Change detection on input pins only
    assign watch_in      = PB_IN_I[7:4];
    assign watch_en      = dir_b_ff[7:4];
    assign mismatch_bits = (watch_in ^ last_read_ff) & watch_en;
    assign mismatch      = |mismatch_bits;

    // External interrupt edge; option bit six set selects rising
    assign ext_pin_now = PB_IN_I[`DGP_PB_EXT_IRQ];
    assign ext_rise    = ext_pin_now & ~ext_pin_ff;
    assign ext_fall    = ~ext_pin_now & ext_pin_ff;
    assign ext_edge    = option_ff[`DGP_OPT_EDGE_SEL] ? ext_rise : ext_fall;

    assign b_access = done & sel_port_b;

    // Port A pin drivers
    genvar gi;
    generate
        for (gi = 0; gi < `DGP_PA_W; gi = gi + 1)
        begin : g_pa
            if (gi == `DGP_PA_TIMER_CLK)
            begin : g_od
                // Open drain: only ever pulls low
                assign PA_OUT_O[gi] = 1'b0;
                assign PA_OE_O[gi]  = ~dir_a_ff[gi] & ~latch_a_ff[gi];
            end
            else
            begin : g_pp
                assign PA_OUT_O[gi] = latch_a_ff[gi];
                assign PA_OE_O[gi]  = ~dir_a_ff[gi];
            end
        end
    endgenerate

    // Port B pin drivers and pull-ups
    assign pullup_on = ~option_ff[`DGP_OPT_PULLUP_EN_N];
    genvar gj;
    generate
        for (gj = 0; gj < `DGP_PB_W; gj = gj + 1)
        begin : g_pb
            assign PB_OUT_O[gj]    = latch_b_ff[gj];
            assign PB_OE_O[gj]     = ~dir_b_ff[gj];
            assign PB_PULLUP_O[gj] = dir_b_ff[gj] & pullup_on;
        end
    endgenerate

    // Shared pin functions
    assign TIMER_CLK_O   = PA_IN_I[`DGP_PA_TIMER_CLK];
    assign SLAVE_SEL_N_O = PA_IN_I[`DGP_PA_SLAVE_SEL] | analog_en[`DGP_PA_SLAVE_SEL];
    assign ANALOG_EN_O   = analog_en;
    assign CHANGE_FLAG_O  = change_flag_ff;
    assign EXT_IRQ_FLAG_O = ext_flag_ff;
    assign WAKE_O         = change_flag_ff;

    // Register updates
    always @*
    begin
        nxt_latch_a    = latch_a_ff;
        nxt_latch_b    = latch_b_ff;
        nxt_dir_a      = dir_a_ff;
        nxt_dir_b      = dir_b_ff;
        nxt_option     = option_ff;
        nxt_analog_cfg = analog_cfg_ff;
        if (wr_done)
        begin
            case (reg_idx)
                `DGP_IDX_PORT_A:
                begin
                    nxt_latch_a = merge_a;
                end
                `DGP_IDX_PORT_B:
                begin
                    nxt_latch_b = merge_b;
                end
                `DGP_IDX_OPTION:
                begin
                    nxt_option = AVS_WRITEDATA_I[7:0];
                end
                `DGP_IDX_DIR_A:
                begin
                    nxt_dir_a = AVS_WRITEDATA_I[5:0];
                end
                `DGP_IDX_DIR_B:
                begin
                    nxt_dir_b = AVS_WRITEDATA_I[7:0];
                end
                `DGP_IDX_ANALOG_CFG:
                begin
                    nxt_analog_cfg = AVS_WRITEDATA_I[2:0];
                end
                default:
                begin
                    nxt_option = option_ff;
                end
            endcase
        end
    end

    // Flag and compare value updates
    always @*
    begin
        nxt_change_flag = change_flag_ff;
        nxt_ext_flag    = ext_flag_ff;
        nxt_last_read   = last_read_ff;
        // Writing zero clears a flag; ones leave it
        if (int_wr)
        begin
            nxt_change_flag = change_flag_ff & AVS_WRITEDATA_I[`DGP_INT_CHANGE];
            nxt_ext_flag    = ext_flag_ff & AVS_WRITEDATA_I[`DGP_INT_EXT];
        end
        // Any port B access re-latches the comparison value
        if (b_access)
        begin
            nxt_last_read = PB_IN_I[7:4];
        end
        // Hardware set wins over a clear in the same cycle
        if (mismatch)
        begin
            nxt_change_flag = 1'b1;
        end
        if (ext_edge)
        begin
            nxt_ext_flag = 1'b1;
        end
    end

    // Read data, captured in the wait cycle
    always @*
    begin
        nxt_rdata = 32'h0000_0000;
        if (rd_capture)
        begin
            case (reg_idx)
                `DGP_IDX_PORT_A:
                begin
                    nxt_rdata[5:0] = pin_a_rd;
                end
                `DGP_IDX_PORT_B:
                begin
                    nxt_rdata[7:0] = PB_IN_I;
                end
                `DGP_IDX_OPTION:
                begin
                    nxt_rdata[7:0] = option_ff;
                end
                `DGP_IDX_DIR_A:
                begin
                    nxt_rdata[5:0] = dir_a_ff;
                end
                `DGP_IDX_DIR_B:
                begin
                    nxt_rdata[7:0] = dir_b_ff;
                end
                `DGP_IDX_ANALOG_CFG:
                begin
                    nxt_rdata[2:0] = analog_cfg_ff;
                end
                `DGP_IDX_INT_CTRL:
                begin
                    nxt_rdata[1:0] = {ext_flag_ff, change_flag_ff};
                end
                default:
                begin
                    nxt_rdata = 32'h0000_0000;
                end
            endcase
        end
        else if (rd_done)
        begin
            nxt_rdata = rdata_ff;
        end
    end

    // Bus side registers
    always @(posedge MCLK_I or posedge SYS_RST_I)
    begin
        if (SYS_RST_I)
        begin
            ack_ff         <= 1'b0;
            rdata_ff       <= 32'h0000_0000;
        end
        else
        begin
            ack_ff         <= req & ~ack_ff;
            rdata_ff       <= nxt_rdata;
        end
    end

    // Port and configuration registers
    always @(posedge MCLK_I or posedge SYS_RST_I)
    begin
        if (SYS_RST_I)
        begin
            latch_a_ff     <= `DGP_RST_LATCH_A;
            latch_b_ff     <= `DGP_RST_LATCH_B;
            dir_a_ff       <= `DGP_RST_DIR_A;
            dir_b_ff       <= `DGP_RST_DIR_B;
            option_ff      <= `DGP_RST_OPTION;
            analog_cfg_ff  <= `DGP_RST_ANALOG_CFG;
        end
        else
        begin
            latch_a_ff     <= nxt_latch_a;
            latch_b_ff     <= nxt_latch_b;
            dir_a_ff       <= nxt_dir_a;
            dir_b_ff       <= nxt_dir_b;
            option_ff      <= nxt_option;
            analog_cfg_ff  <= nxt_analog_cfg;
        end
    end

    // Flags, compare value and edge detector; idle high avoids a false edge
    always @(posedge MCLK_I or posedge SYS_RST_I)
    begin
        if (SYS_RST_I)
        begin
            change_flag_ff <= `DGP_RST_FLAG;
            ext_flag_ff    <= `DGP_RST_FLAG;
            last_read_ff   <= `DGP_RST_CMP;
            ext_pin_ff     <= `DGP_RST_EXT_PIN;
        end
        else
        begin
            change_flag_ff <= nxt_change_flag;
            ext_flag_ff    <= nxt_ext_flag;
            last_read_ff   <= nxt_last_read;
            ext_pin_ff     <= ext_pin_now;
        end
    end

endmodule // dgp_port

`default_nettype wire

// >>> core/dgp_consts.vh
// Register map, field positions and reset values of the dual port block
`ifndef DGP_CONSTS_VH
`define DGP_CONSTS_VH

// Register indexes; byte address is index times four
`define DGP_IDX_PORT_A      8'h05
`define DGP_IDX_PORT_B      8'h06
`define DGP_IDX_INT_CTRL    8'h0B
`define DGP_IDX_OPTION      8'h81
`define DGP_IDX_DIR_A       8'h85
`define DGP_IDX_DIR_B       8'h86
`define DGP_IDX_ANALOG_CFG  8'h9F

// Widths
`define DGP_ADDR_W          10
`define DGP_PA_W            6
`define DGP_PB_W            8

// Reset values
`define DGP_RST_DIR_A       6'h3F
`define DGP_RST_DIR_B       8'hFF
`define DGP_RST_OPTION      8'hFF
`define DGP_RST_ANALOG_CFG  3'h0
`define DGP_RST_LATCH_A     6'h00
`define DGP_RST_LATCH_B     8'h00
`define DGP_RST_FLAG        1'b0
`define DGP_RST_CMP         4'h0
`define DGP_RST_EXT_PIN     1'b1

// Field positions
`define DGP_OPT_PULLUP_EN_N 7
`define DGP_OPT_EDGE_SEL    6
`define DGP_INT_CHANGE      0
`define DGP_INT_EXT         1
`define DGP_PA_TIMER_CLK    4
`define DGP_PA_SLAVE_SEL    5
`define DGP_PB_EXT_IRQ      0
`define DGP_WR_MASK_LSB     8
`define DGP_WR_MASK_EN      16

// Analog map: eight entries of six pin bits, entry 0 in low bits
`define DGP_ANALOG_MAP_DEF  48'h0000_0000_33EF

`endif

// >>> verif/dgp_port_assertions.sv
// Port-level assertion checker for the dual port block
`timescale 1ns/1ps
`default_nettype none
module dgp_port_chk (
    // Clock, reset and bus
    input wire logic        MCLK_I,
    input wire logic        SYS_RST_I,
    input wire logic [9:0]  AVS_ADDRESS_I,
    input wire logic        AVS_READ_I,
    input wire logic        AVS_WRITE_I,
    input wire logic [31:0] AVS_READDATA_O,
    input wire logic        AVS_WAITREQUEST_O,
    // Pins and flags
    input wire logic [5:0]  PA_IN_I,
    input wire logic [5:0]  PA_OUT_O,
    input wire logic [7:0]  PB_IN_I,
    input wire logic [7:0]  PB_OE_O,
    input wire logic [7:0]  PB_PULLUP_O,
    input wire logic        TIMER_CLK_O,
    input wire logic        SLAVE_SEL_N_O,
    input wire logic [5:0]  ANALOG_EN_O,
    input wire logic        CHANGE_FLAG_O,
    input wire logic        WAKE_O
);
    default clocking @(posedge MCLK_I); endclocking
    default disable iff (SYS_RST_I);
    logic       req;
    logic       done;
    logic       miss;
    logic [3:0] cmp_ff;
    assign req  = AVS_READ_I | AVS_WRITE_I;
    assign done = req & ~AVS_WAITREQUEST_O;
    assign miss = |((PB_IN_I[7:4] ^ cmp_ff) & ~PB_OE_O[7:4]);
    // Compare value mirror
    always @(posedge MCLK_I or posedge SYS_RST_I)
        if (SYS_RST_I)
            cmp_ff <= 4'h0;
        else if (done && AVS_ADDRESS_I[9:2] == 8'h06)
            cmp_ff <= PB_IN_I[7:4];
    a_wait_first: assert property ($rose(req) |-> AVS_WAITREQUEST_O)
        else $error("no wait cycle");
    a_wait_one: assert property (req && AVS_WAITREQUEST_O |=> !AVS_WAITREQUEST_O)
        else $error("wait too long");
    a_pa_upper: assert property (done && AVS_ADDRESS_I[9:2] == 8'h05 |-> AVS_READDATA_O[31:6] == 26'h0)
        else $error("upper bits set");
    a_pb_read: assert property (done && AVS_READ_I && AVS_ADDRESS_I[9:2] == 8'h06 && $stable(PB_IN_I)
        |-> AVS_READDATA_O[7:0] == PB_IN_I)
        else $error("port read wrong");
    a_pullup_out: assert property ((PB_PULLUP_O & PB_OE_O) == 8'h00)
        else $error("pullup on output");
    a_od_low: assert property (PA_OUT_O[4] == 1'b0 && TIMER_CLK_O == PA_IN_I[4])
        else $error("a4 wrong");
    a_slave_sel: assert property (!ANALOG_EN_O[5] |-> SLAVE_SEL_N_O == PA_IN_I[5])
        else $error("select wrong");
    a_change_set: assert property (miss && !(done && AVS_ADDRESS_I[9:2] == 8'h06) |=> CHANGE_FLAG_O)
        else $error("change missed");
    a_wake_flag: assert property (WAKE_O == CHANGE_FLAG_O)
        else $error("wake wrong");
endmodule // dgp_port_chk
bind dgp_port dgp_port_chk u_chk (.MCLK_I(MCLK_I), .SYS_RST_I(SYS_RST_I),
    .AVS_ADDRESS_I(AVS_ADDRESS_I), .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I),
    .AVS_READDATA_O(AVS_READDATA_O), .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O),
    .PA_IN_I(PA_IN_I), .PA_OUT_O(PA_OUT_O), .PB_IN_I(PB_IN_I), .PB_OE_O(PB_OE_O),
    .PB_PULLUP_O(PB_PULLUP_O), .TIMER_CLK_O(TIMER_CLK_O), .SLAVE_SEL_N_O(SLAVE_SEL_N_O),
    .ANALOG_EN_O(ANALOG_EN_O), .CHANGE_FLAG_O(CHANGE_FLAG_O), .WAKE_O(WAKE_O));
`default_nettype wire

// >>> verif/dgp_board.sv
// Board model: switches on every pin, overridden where the block drives
`timescale 1ns/1ps
`default_nettype none
module dgp_board (
    input  wire logic [5:0] a_out_i,
    input  wire logic [5:0] a_oe_i,
    input  wire logic [5:0] a_ext_i,
    input  wire logic [7:0] b_out_i,
    input  wire logic [7:0] b_oe_i,
    input  wire logic [7:0] b_ext_i,
    output wire logic [5:0] a_pin_o,
    output wire logic [7:0] b_pin_o
);
    assign a_pin_o = (a_oe_i & a_out_i) | (~a_oe_i & a_ext_i);
    assign b_pin_o = (b_oe_i & b_out_i) | (~b_oe_i & b_ext_i);
endmodule // dgp_board
`default_nettype wire

// >>> verif/dgp_port_tb.sv
// Self-checking testbench for the dual port block
`timescale 1ns/1ps
`default_nettype none
module dgp_port_tb;
    logic        clk = 0, rst = 1, rd = 0, wr = 0, wreq, ssn, tclk, chg, exf, wake;
    logic [9:0]  addr = 0;
    logic [31:0] wd = 0, rdata, q;
    logic [5:0]  pa_in, pa_out, pa_oe, aen, pa_ext = 6'h3F;
    logic [7:0]  pb_in, pb_out, pb_oe, pb_pu, pb_ext = 8'hA5;
    int          fail_count = 0, n_tests = 0;
    dgp_port dut (.MCLK_I(clk), .SYS_RST_I(rst), .AVS_ADDRESS_I(addr), .AVS_READ_I(rd),
        .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wd), .AVS_READDATA_O(rdata),
        .AVS_WAITREQUEST_O(wreq), .PA_IN_I(pa_in), .PA_OUT_O(pa_out), .PA_OE_O(pa_oe),
        .PB_IN_I(pb_in), .PB_OUT_O(pb_out), .PB_OE_O(pb_oe), .PB_PULLUP_O(pb_pu),
        .TIMER_CLK_O(tclk), .SLAVE_SEL_N_O(ssn), .ANALOG_EN_O(aen),
        .CHANGE_FLAG_O(chg), .EXT_IRQ_FLAG_O(exf), .WAKE_O(wake));
    dgp_board board (.a_out_i(pa_out), .a_oe_i(pa_oe), .a_ext_i(pa_ext), .b_out_i(pb_out),
        .b_oe_i(pb_oe), .b_ext_i(pb_ext), .a_pin_o(pa_in), .b_pin_o(pb_in));
    initial forever #12.5 clk = ~clk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] d);
        @(posedge clk);
        rd <= ~w;
        wr <= w;
        addr <= {idx, 2'b00};
        wd <= d;
        @(posedge clk);
        while (wreq) @(posedge clk);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        @(negedge clk);
    endtask
    task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
        bus(1'b0, idx, 32'h0);
        chk(q, exp);
    endtask
    task automatic pins_b(input logic [7:0] v);
        @(posedge clk);
        pb_ext <= v;
        repeat (3) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic t_reset;
        chk(pb_pu, 8'h00);
        chk(aen, 6'h2F);
        chk(exf, 1'b0);
        rdc(8'h85, 32'h3F);
        rdc(8'h86, 32'hFF);
        rdc(8'h81, 32'hFF);
        rdc(8'h9F, 32'h00);
        rdc(8'h05, 32'h10);
        bus(1'b1, 8'h40, 32'hFF);
        rdc(8'h40, 32'h00);
    endtask
    task automatic t_port_a;
        bus(1'b1, 8'h9F, 32'h01);
        chk(aen, 6'h0F);
        bus(1'b1, 8'h9F, 32'h02);
        chk(aen, 6'h03);
        bus(1'b1, 8'h9F, 32'h06);
        chk(aen, 6'h00);
        rdc(8'h05, 32'h3F);
        bus(1'b1, 8'h85, 32'h00);
        bus(1'b1, 8'h05, 32'h3F);
        chk(pa_out, 6'h2F);
        chk(pa_oe, 6'h2F);
        @(posedge clk);
        pa_ext <= 6'h00;
        bus(1'b1, 8'h05, 32'h10100);
        chk(pa_out, 6'h2E);
    endtask
    task automatic t_port_b;
        bus(1'b1, 8'h86, 32'hF0);
        bus(1'b1, 8'h81, 32'h7F);
        chk(pb_pu, 8'hF0);
        chk(pb_oe, 8'h0F);
        bus(1'b1, 8'h06, 32'h3C);
        chk(pb_out, 8'h3C);
        rdc(8'h06, 32'hAC);
        bus(1'b1, 8'h0B, 32'h0);
    endtask
    task automatic t_change;
        pins_b(8'h55);
        chk(chg, 1'b1);
        rdc(8'h0B, 32'h01);
        bus(1'b1, 8'h0B, 32'h0);
        chk(chg, 1'b1);
        rdc(8'h06, 32'h5C);
        bus(1'b1, 8'h0B, 32'h0);
        chk(chg, 1'b0);
        bus(1'b1, 8'h86, 32'h70);
        bus(1'b1, 8'h06, 32'h80);
        pins_b(8'h55);
        chk(chg, 1'b0);
    endtask
    task automatic t_edge;
        bus(1'b1, 8'h86, 32'hFF);
        bus(1'b1, 8'h0B, 32'h0);
        pins_b(8'h54);
        chk(exf, 1'b0);
        pins_b(8'h55);
        chk(exf, 1'b1);
        bus(1'b1, 8'h0B, 32'h0);
        bus(1'b1, 8'h81, 32'h3F);
        pins_b(8'h54);
        chk({exf, pb_pu}, 9'h1FF);
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial
    begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        t_reset;
        t_port_a;
        t_port_b;
        t_change;
        t_edge;
        conclude;
    end
    initial
    begin
        repeat (5000) @(posedge clk);
        fail_count++;
        conclude;
    end
endmodule // dgp_port_tb
`default_nettype wire
